/* File: pkg/lin_resp_pkg.sv */
// Shared constants, types and state codes for the LIN responder frame receiver
package lin_resp_pkg;
    // Link and clock rates
    localparam int          SYS_HZ          = 250_000_000;
    localparam int          LIN_BAUD        = 19200;
    localparam int          BIT_CYCLES_DEF  = SYS_HZ / LIN_BAUD;
    localparam logic [3:0]  CNT_DIV_LAST    = 4'hf;
    // Frame constants
    localparam logic [7:0]  SYNC_BYTE       = 8'h55;
    localparam logic [7:0]  MSG_NOT_FOUND   = 8'hff;
    localparam logic [7:0]  MSG_RESPOND     = 8'h01;
    localparam logic [7:0]  MSG_RECEIVE     = 8'h02;
    localparam logic [5:0]  ID_RESPOND      = 6'h08;
    localparam logic [5:0]  ID_RECEIVE      = 6'h39;
    localparam logic [2:0]  SYNC_INTERVALS  = 3'h5;
    localparam logic [3:0]  RX_LEN          = 4'h8;
    localparam logic [3:0]  TX_LEN          = 4'h4;
    localparam logic [3:0]  STOP_BIT_IDX    = 4'h9;
    // Frame sequencing states, Gray along the receive path
    typedef enum logic [2:0] {
        ST_WAIT_BREAK = 3'b000,
        ST_SYNC       = 3'b001,
        ST_PID        = 3'b011,
        ST_RX         = 3'b010,
        ST_GAP        = 3'b110,
        ST_TX         = 3'b111
    } frame_state_t;
    // Received word towards the application
    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } rx_word_t;
    // Completed frame stages
    typedef struct packed {
        logic brk;
        logic sync;
        logic pid;
    } stage_flags_t;
    typedef logic [3:0][7:0] resp_data_t;
endpackage

/* File: core/two_entry_buffer.sv */
// Two-entry valid/ready buffer for received frame words
`timescale 1ns/1ps
module two_entry_buffer
    import lin_resp_pkg::*;
(
    // Clock and reset
    input  wire logic     sys_clk_in,
    input  wire logic     rst_n_in,
    // Fill side
    input  wire logic     in_valid_in,
    input  rx_word_t      in_data_in,
    output logic          in_ready_out,
    // Drain side
    output logic          out_valid_out,
    output rx_word_t      out_data_out,
    input  wire logic     out_ready_in
);
    rx_word_t   slot0_ff;
    rx_word_t   slot1_ff;
    logic [1:0] count_ff;
    rx_word_t   nxt_slot0;
    rx_word_t   nxt_slot1;
    logic [1:0] nxt_count;
    logic       push;
    logic       pop;

    // Full and empty straight from the count
    assign in_ready_out  = (count_ff != 2'h2);
    assign out_valid_out = (count_ff != 2'h0);
    assign out_data_out  = slot0_ff;
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    // Slot moves; head is always slot0
    always_comb
    begin
        nxt_slot0 = slot0_ff;
        nxt_slot1 = slot1_ff;
        nxt_count = count_ff;
        if (push && pop)
        begin
            if (count_ff == 2'h1)
                nxt_slot0 = in_data_in;
            else
            begin
                nxt_slot0 = slot1_ff;
                nxt_slot1 = in_data_in;
            end
        end
        else if (pop)
        begin
            nxt_slot0 = slot1_ff;
            nxt_count = count_ff - 2'h1;
        end
        else if (push)
        begin
            if (count_ff == 2'h0)
                nxt_slot0 = in_data_in;
            else
                nxt_slot1 = in_data_in;
            nxt_count = count_ff + 2'h1;
        end
    end

    // Registers
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            slot0_ff <= '0;
            slot1_ff <= '0;
            count_ff <= 2'h0;
        end
        else
        begin
            slot0_ff <= nxt_slot0;
            slot1_ff <= nxt_slot1;
            count_ff <= nxt_count;
        end
    end
endmodule

/* File: core/lin_responder_frame_receiver.sv */
// LIN responder: break and sync check, identifier lookup, response receive or transmit
//
// What this block does
// - Bit timing comes from a fixed local divider; sync only checked, never tracked.
// - Frame accepted only if byte after break equals 0x55.
// - No timeout; a stalled frame waits for more bytes indefinitely.
// - State machine picks next unfinished stage from stored flags on each event.
// - Free-running edge counter measures break low time when compare_mode_in is low.
// - Sync measured from counter difference to the last edge (last_ff) on each raw fall or rise.
// - Five edge intervals of sync field checked before sync is valid.
// - Unknown identifier looks up as 0xff and no response follows.
// - Programmable gap between identifier stop bit and first response start bit.
// - Each received byte passes a receive holding buffer read by the state machine.
// - Link runs at 19200 bits per second.
// - Bad checksum still delivers data bytes but no success pulse.
// - Identifier 0x08 makes the responder send its data response.
// - Sixteen-bit up-counter on a divide-by-16 system clock prescaler tick with overflow event.
// - Falling capture latches counter on fall, or compares and flags a match.
// - Rising capture latches counter on each rising edge with an event.
// - Enhanced checksum over protected identifier and data bytes.
`timescale 1ns/1ps
module lin_responder_frame_receiver
    import lin_resp_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEF
)
(
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    // LIN transceiver pins
    input  wire logic        lin_rx_in,
    output logic             lin_tx_out,
    // Configuration
    input  wire logic [15:0] break_min_in,
    input  wire logic [15:0] reply_gap_cycles_in,
    input  wire logic        compare_mode_in,
    input  wire logic [15:0] compare_value_in,
    input  resp_data_t       resp_data_in,
    // Counter and capture view
    output logic [15:0]      edge_interval_counter_out,
    output logic [15:0]      falling_edge_capture_out,
    output logic [15:0]      rising_edge_capture_out,
    output logic             counter_overflow_out,
    output logic             fall_capture_evt_out,
    output logic             rise_capture_evt_out,
    output logic             compare_match_out,
    // Frame status pulses
    output logic             break_seen_out,
    output logic             sync_error_out,
    output logic             frame_ok_out,
    // Received data stream
    output logic             rx_valid_out,
    output rx_word_t         rx_data_out,
    input  wire logic        rx_ready_in
);
    localparam logic [15:0] BIT_LAST  = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] BIT_HALF  = 16'(BIT_CYCLES / 2);
    localparam logic [15:0] TICK_LO   = 16'(BIT_CYCLES / 32);
    localparam logic [15:0] TICK_HI   = 16'((BIT_CYCLES * 3) / 32);

    // Identifier table lookup
    function automatic logic [7:0] id_lookup(input logic [7:0] pid);
        if (pid[5:0] == ID_RESPOND)
            return MSG_RESPOND;
        if (pid[5:0] == ID_RECEIVE)
            return MSG_RECEIVE;
        return MSG_NOT_FOUND;
    endfunction

    // Add with end-around carry
    function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0] + {7'h0, s[8]};
    endfunction

    // First stage not yet done
    function automatic frame_state_t next_stage(input stage_flags_t f, input logic tx_dir);
        if (!f.brk)
            return ST_WAIT_BREAK;
        if (!f.sync)
            return ST_SYNC;
        if (!f.pid)
            return ST_PID;
        return tx_dir ? ST_GAP : ST_RX;
    endfunction

    // Pin synchroniser and edge detect; the first stage is never looked at
    logic rx_meta_ff, rx_sync_ff, rx_prev_ff;
    logic fall, rise;
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
            rx_prev_ff <= 1'b1;
        end
        else
        begin
            rx_meta_ff <= lin_rx_in;
            rx_sync_ff <= rx_meta_ff;
            rx_prev_ff <= rx_sync_ff;
        end
    end
    assign fall = rx_prev_ff & ~rx_sync_ff;
    assign rise = ~rx_prev_ff & rx_sync_ff;

    // Edge counter and captures
    logic [3:0]  div_ff, nxt_div;
    logic [15:0] cnt_ff, nxt_cnt, fcap_ff, nxt_fcap, rcap_ff, nxt_rcap, last_ff, nxt_last;
    logic        ovf_ff, nxt_ovf, fevt_ff, nxt_fevt, revt_ff, nxt_revt, cmp_ff, nxt_cmp;
    logic        tick;
    assign tick = (div_ff == CNT_DIV_LAST);
    always_comb
    begin
        nxt_div  = tick ? 4'h0 : div_ff + 4'h1;
        nxt_cnt  = tick ? cnt_ff + 16'h1 : cnt_ff;
        nxt_ovf  = tick && (cnt_ff == 16'hffff);
        nxt_fcap = compare_mode_in ? compare_value_in : (fall ? cnt_ff : fcap_ff);
        nxt_fevt = fall && !compare_mode_in;
        nxt_cmp  = compare_mode_in && tick && (cnt_ff == compare_value_in);
        nxt_rcap = rise ? cnt_ff : rcap_ff;
        nxt_revt = rise;
        nxt_last = (fall || rise) ? cnt_ff : last_ff;
    end
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            {div_ff, cnt_ff, fcap_ff, rcap_ff, last_ff, ovf_ff, fevt_ff, revt_ff, cmp_ff} <= '0;
        end
        else
        begin
            {div_ff, cnt_ff, fcap_ff}  <= {nxt_div, nxt_cnt, nxt_fcap};
            {rcap_ff, last_ff, ovf_ff} <= {nxt_rcap, nxt_last, nxt_ovf};
            {fevt_ff, revt_ff, cmp_ff} <= {nxt_fevt, nxt_revt, nxt_cmp};
        end
    end

    // Byte receiver with one-byte holding buffer
    frame_state_t state_ff, nxt_state;
    logic        rx_en, pop;
    logic        ub_ff, nxt_ub, have_ff, nxt_have;
    logic [15:0] ucnt_ff, nxt_ucnt;
    logic [3:0]  ubit_ff, nxt_ubit;
    logic [7:0]  ush_ff, nxt_ush, hold_ff, nxt_hold;
    assign rx_en = (state_ff == ST_SYNC) || (state_ff == ST_PID) || (state_ff == ST_RX);
    always_comb
    begin
        nxt_ub   = ub_ff;
        nxt_ucnt = ucnt_ff;
        nxt_ubit = ubit_ff;
        nxt_ush  = ush_ff;
        nxt_hold = hold_ff;
        nxt_have = pop ? 1'b0 : have_ff;
        if (!rx_en)
        begin
            nxt_ub   = 1'b0;
            nxt_have = 1'b0;
        end
        else if (!ub_ff)
        begin
            if (fall)
            begin
                nxt_ub   = 1'b1;
                nxt_ucnt = BIT_HALF;
                nxt_ubit = 4'h0;
            end
        end
        else if (ucnt_ff != 16'h0)
            nxt_ucnt = ucnt_ff - 16'h1;
        else
        begin
            nxt_ucnt = BIT_LAST;
            nxt_ubit = ubit_ff + 4'h1;
            if (ubit_ff == 4'h0 && rx_sync_ff)
                nxt_ub = 1'b0; // False start
            else if (ubit_ff == STOP_BIT_IDX)
            begin
                nxt_ub = 1'b0;
                if (rx_sync_ff)
                begin
                    nxt_hold = ush_ff;
                    nxt_have = 1'b1;
                end
            end
            else if (ubit_ff != 4'h0)
                nxt_ush = {rx_sync_ff, ush_ff[7:1]};
        end
    end
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            {ub_ff, ucnt_ff, ubit_ff, ush_ff, hold_ff, have_ff} <= '0;
        end
        else
        begin
            {ub_ff, ucnt_ff, ubit_ff}    <= {nxt_ub, nxt_ucnt, nxt_ubit};
            {ush_ff, hold_ff, have_ff}   <= {nxt_ush, nxt_hold, nxt_have};
        end
    end

    // Frame sequencing and response transmitter
    stage_flags_t flags_ff, nxt_flags;
    logic [2:0]  scnt_ff, nxt_scnt;
    logic        seen_ff, nxt_seen, txdir_ff, nxt_txdir;
    logic [7:0]  csum_ff, nxt_csum;
    logic [3:0]  idx_ff, nxt_idx, tbit_ff, nxt_tbit;
    logic [15:0] gap_ff, nxt_gap, tcnt_ff, nxt_tcnt, ival;
    logic [9:0]  tsh_ff, nxt_tsh;
    logic        tb_ff, nxt_tb, line_ff, nxt_line;
    logic        brk_ff, nxt_brk, serr_ff, nxt_serr, ok_ff, nxt_ok;
    logic        buf_valid, buf_ready;
    rx_word_t    buf_data;
    logic [7:0]  tx_byte;
    assign ival = cnt_ff - last_ff;
    always_comb
    begin
        nxt_state = state_ff;
        nxt_flags = flags_ff;
        nxt_scnt  = scnt_ff;
        nxt_seen  = seen_ff;
        nxt_txdir = txdir_ff;
        nxt_csum  = csum_ff;
        nxt_idx   = idx_ff;
        nxt_gap   = gap_ff;
        nxt_tsh   = tsh_ff;
        nxt_tb    = tb_ff;
        nxt_tcnt  = tcnt_ff;
        nxt_tbit  = tbit_ff;
        nxt_brk   = 1'b0;
        nxt_serr  = 1'b0;
        nxt_ok    = 1'b0;
        pop       = 1'b0;
        buf_valid = 1'b0;
        buf_data  = '{last: (idx_ff == RX_LEN - 4'h1), data: hold_ff};
        tx_byte   = (idx_ff < TX_LEN) ? resp_data_in[idx_ff[1:0]] : ~csum_ff;
        unique case (state_ff)
            ST_WAIT_BREAK:
            begin
                nxt_flags = '0;
                nxt_seen  = 1'b0;
                nxt_scnt  = 3'h0;
                if (revt_ff && (rcap_ff - fcap_ff) > break_min_in)
                begin
                    nxt_flags.brk = 1'b1;
                    nxt_brk       = 1'b1;
                    nxt_state     = next_stage(nxt_flags, 1'b0);
                end
            end
            ST_SYNC:
            begin
                if ((fall || rise) && scnt_ff < SYNC_INTERVALS)
                begin
                    nxt_seen = 1'b1;
                    if (seen_ff && ival >= TICK_LO && ival <= TICK_HI)
                        nxt_scnt = scnt_ff + 3'h1;
                    else if (seen_ff)
                    begin
                        nxt_serr  = 1'b1;
                        nxt_state = ST_WAIT_BREAK;
                    end
                end
                if (have_ff)
                begin
                    pop = 1'b1;
                    if (hold_ff == SYNC_BYTE && scnt_ff == SYNC_INTERVALS)
                    begin
                        nxt_flags.sync = 1'b1;
                        nxt_state      = next_stage(nxt_flags, 1'b0);
                    end
                    else
                    begin
                        nxt_serr  = 1'b1;
                        nxt_state = ST_WAIT_BREAK;
                    end
                end
            end
            ST_PID:
            begin
                if (have_ff)
                begin
                    pop      = 1'b1;
                    nxt_csum = hold_ff;
                    nxt_idx  = 4'h0;
                    nxt_gap  = 16'h0;
                    if (id_lookup(hold_ff) == MSG_NOT_FOUND)
                        nxt_state = ST_WAIT_BREAK;
                    else
                    begin
                        nxt_txdir     = (id_lookup(hold_ff) == MSG_RESPOND);
                        nxt_flags.pid = 1'b1;
                        nxt_state     = next_stage(nxt_flags, nxt_txdir);
                    end
                end
            end
            ST_RX:
            begin
                if (have_ff && idx_ff < RX_LEN)
                begin
                    buf_valid = 1'b1;
                    if (buf_ready)
                    begin
                        pop      = 1'b1;
                        nxt_csum = csum_add(csum_ff, hold_ff);
                        nxt_idx  = idx_ff + 4'h1;
                    end
                end
                else if (have_ff)
                begin
                    pop       = 1'b1;
                    nxt_ok    = (hold_ff == ~csum_ff);
                    nxt_state = ST_WAIT_BREAK;
                end
            end
            ST_GAP:
            begin
                nxt_gap = gap_ff + 16'h1;
                if (gap_ff >= reply_gap_cycles_in)
                    nxt_state = ST_TX;
            end
            ST_TX:
            begin
                if (!tb_ff)
                begin
                    if (idx_ff <= TX_LEN)
                    begin
                        nxt_tsh  = {1'b1, tx_byte, 1'b0};
                        nxt_tb   = 1'b1;
                        nxt_tcnt = BIT_LAST;
                        nxt_tbit = 4'h0;
                        nxt_idx  = idx_ff + 4'h1;
                        nxt_csum = (idx_ff < TX_LEN) ? csum_add(csum_ff, tx_byte) : csum_ff;
                    end
                    else
                        nxt_state = ST_WAIT_BREAK;
                end
                else if (tcnt_ff != 16'h0)
                    nxt_tcnt = tcnt_ff - 16'h1;
                else if (tbit_ff == STOP_BIT_IDX)
                    nxt_tb = 1'b0;
                else
                begin
                    nxt_tsh  = {1'b1, tsh_ff[9:1]};
                    nxt_tbit = tbit_ff + 4'h1;
                    nxt_tcnt = BIT_LAST;
                end
            end
            default:
                nxt_state = ST_WAIT_BREAK;
        endcase
        nxt_line = nxt_tb ? nxt_tsh[0] : 1'b1;
    end
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            {flags_ff, scnt_ff, seen_ff, txdir_ff, csum_ff, idx_ff, gap_ff} <= '0;
            {tb_ff, tcnt_ff, tbit_ff, brk_ff, serr_ff, ok_ff}               <= '0;
            state_ff <= ST_WAIT_BREAK;
            tsh_ff   <= 10'h3ff;
            line_ff  <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            {flags_ff, scnt_ff, seen_ff, txdir_ff} <= {nxt_flags, nxt_scnt, nxt_seen, nxt_txdir};
            {csum_ff, idx_ff, gap_ff, tsh_ff}      <= {nxt_csum, nxt_idx, nxt_gap, nxt_tsh};
            {tb_ff, tcnt_ff, tbit_ff, line_ff}     <= {nxt_tb, nxt_tcnt, nxt_tbit, nxt_line};
            {brk_ff, serr_ff, ok_ff}               <= {nxt_brk, nxt_serr, nxt_ok};
        end
    end

    // A stalled receiver holds the byte; further bytes overrun the holding buffer
    two_entry_buffer u_rx_buf (
        .sys_clk_in    (sys_clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (buf_valid),
        .in_data_in    (buf_data),
        .in_ready_out  (buf_ready),
        .out_valid_out (rx_valid_out),
        .out_data_out  (rx_data_out),
        .out_ready_in  (rx_ready_in)
    );

    // Outputs
    assign lin_tx_out                = line_ff;
    assign edge_interval_counter_out = cnt_ff;
    assign falling_edge_capture_out  = fcap_ff;
    assign rising_edge_capture_out   = rcap_ff;
    assign counter_overflow_out      = ovf_ff;
    assign fall_capture_evt_out      = fevt_ff;
    assign rise_capture_evt_out      = revt_ff;
    assign compare_match_out         = cmp_ff;
    assign break_seen_out            = brk_ff;
    assign sync_error_out            = serr_ff;
    assign frame_ok_out              = ok_ff;
endmodule

/* File: dv/lin_responder_monitor.sv */
// Port-level assertions for the LIN responder frame receiver
`timescale 1ns/1ps
module lin_responder_monitor
    import lin_resp_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    // Watched ports
    input  wire logic        lin_tx_out,
    input  wire logic [15:0] edge_interval_counter_out,
    input  wire logic        rise_capture_evt_out,
    input  wire logic        break_seen_out,
    input  wire logic        sync_error_out,
    input  wire logic        frame_ok_out,
    input  wire logic        rx_valid_out,
    input  wire rx_word_t    rx_data_out,
    input  wire logic        rx_ready_in
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    // Counter steps by one, once per prescaler period
    property p_cnt_step;
        $changed(edge_interval_counter_out)
            |-> edge_interval_counter_out == $past(edge_interval_counter_out) + 16'h1;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter jumped");
    property p_cnt_hold;
        $changed(edge_interval_counter_out) |=> $stable(edge_interval_counter_out) [*8];
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("counter ran fast");
    // A stalled word must wait unchanged
    property p_rx_hold;
        rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("stalled word lost");
    // Break only on a rising capture
    property p_brk_rise;
        break_seen_out |-> $past(rise_capture_evt_out);
    endproperty
    a_brk_rise: assert property (p_brk_rise) else $error("break without rise");
    property p_brk_pulse;
        break_seen_out |=> !break_seen_out;
    endproperty
    a_brk_pulse: assert property (p_brk_pulse) else $error("break pulse long");
    property p_rise_single;
        rise_capture_evt_out |=> !rise_capture_evt_out;
    endproperty
    a_rise_single: assert property (p_rise_single) else $error("double rise event");
    // Failed sync sends nothing
    property p_err_quiet;
        sync_error_out |=> lin_tx_out [*8];
    endproperty
    a_err_quiet: assert property (p_err_quiet) else $error("reply after sync error");
    // No sync verdict right after the break
    property p_brk_quiet;
        break_seen_out |=> (!sync_error_out && lin_tx_out) [*8];
    endproperty
    a_brk_quiet: assert property (p_brk_quiet) else $error("early sync verdict");

    // Main scenarios reached
    c_break: cover property (break_seen_out);
    c_sync_err: cover property (sync_error_out);
    c_frame_ok: cover property (frame_ok_out);
    c_stall: cover property (rx_valid_out && !rx_ready_in);
endmodule

/* File: dv/lin_commander_model.sv */
// Behavioural LIN commander node on the bus
`timescale 1ns/1ps
module lin_commander_model #(
    parameter int BIT = 320
)
(
    // Clock
    input  wire logic sys_clk_in,
    // Bus lines
    output logic      bus_out,
    input  wire logic bus_in
);
    // Released bus idles high through the pull-up
    initial bus_out = 1'b1;

    // Drive a level for whole bit times at the nominal rate
    task automatic hold(input logic v, input int bits);
        @(posedge sys_clk_in);
        #1 bus_out = v;
        repeat (bits * BIT - 1) @(posedge sys_clk_in);
    endtask
    task automatic send_break(input int bits);
        hold(1'b0, bits);
        hold(1'b1, 1);
    endtask
    // 8N1, LSB first; the commander supplies data and checksum
    task automatic send_byte(input logic [7:0] b);
        hold(1'b0, 1);
        for (int i = 0; i < 8; i++)
            hold(b[i], 1);
        hold(1'b1, 1);
    endtask
    // Mid-bit sampling of a response byte, bounded wait for start
    task automatic recv_byte(output logic [7:0] b, output bit ok);
        int n = 0;
        ok = 1'b0;
        while (bus_in !== 1'b0 && n < 40000)
        begin
            @(posedge sys_clk_in);
            n++;
        end
        repeat (BIT / 2) @(posedge sys_clk_in);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge sys_clk_in);
            b[i] = bus_in;
        end
        repeat (BIT) @(posedge sys_clk_in);
        ok = (bus_in === 1'b1) && (n < 40000);
    endtask
endmodule

/* File: dv/lin_responder_frame_receiver_tb_top.sv */
// Self-checking bench for the LIN responder frame receiver
`timescale 1ns/1ps
module lin_responder_frame_receiver_tb_top;
    import lin_resp_pkg::*;
    localparam int BITC = 64; // Short bit keeps the run small
    logic        sys_clk_in = 1'b0;
    logic        rst_n_in   = 1'b0;
    logic        rx_ready   = 1'b1;
    logic        cmd_drive, lin_tx, rx_valid, brk, serr, fok;
    logic [15:0] gap = 16'h0100;
    logic [15:0] cnt;
    wire logic   lin_bus;
    rx_word_t    rx_data;
    resp_data_t  resp = {8'h44, 8'h33, 8'h22, 8'h11};
    int          fails = 0, n_tests = 0, n_brk = 0, n_serr = 0, n_fok = 0, n_txlow = 0;
    rx_word_t    got[$];

    // Open-drain bus: either party pulls low
    assign lin_bus = cmd_drive & lin_tx;
    always #2 sys_clk_in = ~sys_clk_in;

    lin_responder_frame_receiver #(.BIT_CYCLES(BITC)) dut (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .lin_rx_in(lin_bus),
        .lin_tx_out(lin_tx), .break_min_in(16'h0028), .reply_gap_cycles_in(gap),
        .compare_mode_in(1'b0), .compare_value_in(16'h0000), .resp_data_in(resp),
        .edge_interval_counter_out(cnt), .falling_edge_capture_out(),
        .rising_edge_capture_out(), .counter_overflow_out(), .fall_capture_evt_out(),
        .rise_capture_evt_out(), .compare_match_out(), .break_seen_out(brk),
        .sync_error_out(serr), .frame_ok_out(fok), .rx_valid_out(rx_valid),
        .rx_data_out(rx_data), .rx_ready_in(rx_ready));
    lin_commander_model #(.BIT(BITC)) m (
        .sys_clk_in(sys_clk_in), .bus_out(cmd_drive), .bus_in(lin_bus));

    // Event tallies and stream sink
    always @(posedge sys_clk_in)
    begin
        if (brk === 1'b1) n_brk++;
        if (serr === 1'b1) n_serr++;
        if (fok === 1'b1) n_fok++;
        if (lin_tx !== 1'b1) n_txlow++;
        if (rx_valid === 1'b1 && rx_ready === 1'b1) got.push_back(rx_data);
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] act);
        n_tests++;
        if (act !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, act);
        end
    endtask
    task automatic tally_and_finish;
        $display("Counts: %0d checks, %0d mismatches", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Sum with end-around carry
    function automatic logic [7:0] add_c(input logic [7:0] s, input logic [7:0] d);
        logic [8:0] t;
        t = {1'b0, s} + {1'b0, d};
        return t[7:0] + {7'h00, t[8]};
    endfunction
    task automatic header(input logic [7:0] syn, input logic [7:0] pid);
        m.send_break(13);
        m.send_byte(syn);
        m.send_byte(pid);
    endtask
    task automatic clear;
        @(posedge sys_clk_in);
        #1 {n_brk, n_serr, n_fok, n_txlow} = '0;
        got.delete();
    endtask

    // Receive frame, stalled sink for three words, good or bad checksum
    task automatic t_rx(input bit bad);
        logic [7:0] s = 8'h39;
        clear();
        rx_ready = 1'b0;
        header(8'h55, 8'h39);
        for (int i = 0; i < 8; i++)
        begin
            if (i == 3) #1 rx_ready = 1'b1;
            m.send_byte(8'h70 + 8'(i));
            s = add_c(s, 8'h70 + 8'(i));
        end
        m.send_byte(bad ? ~s ^ 8'h01 : ~s);
        repeat (4 * BITC) @(posedge sys_clk_in);
        chk("breaks", 16'h1, 16'(n_brk));
        chk("words", 16'h8, 16'(got.size()));
        for (int i = 0; i < 8 && i < got.size(); i++)
            chk("word", {7'h00, i == 7, 8'h70 + 8'(i)}, {7'h00, got[i]});
        chk("frame ok", {15'h0, !bad}, 16'(n_fok));
        $display("done rx frame bad=%0d", bad);
    endtask

    // Response frame: gap, four data bytes and checksum
    task automatic t_tx;
        logic [7:0] s, b;
        bit ok;
        int n = 0;
        s = 8'h08;
        header(8'h55, 8'h08);
        while (lin_tx === 1'b1 && n < 4000)
        begin
            @(posedge sys_clk_in);
            n++;
        end
        chk("gap", 16'h1, {15'h0, n >= gap - BITC && n <= gap});
        for (int i = 0; i < 5; i++)
        begin
            m.recv_byte(b, ok);
            if (i < 4) s = add_c(s, resp[i]);
            chk("tx byte", {8'h00, i < 4 ? resp[i] : ~s}, {8'h00, b});
            chk("tx stop", 16'h1, {15'h0, ok});
        end
        $display("done tx frame");
    endtask

    // Bad sync, unknown identifier and short break are all ignored
    task automatic t_reject;
        clear();
        header(8'h54, 8'h08);
        chk("sync error", 16'h1, 16'(n_serr));
        header(8'h55, 8'h10);
        m.send_break(8);
        repeat (4 * BITC) @(posedge sys_clk_in);
        chk("breaks", 16'h2, 16'(n_brk));
        chk("tx low", 16'h0, 16'(n_txlow));
        chk("words", 16'h0, 16'(got.size()));
        $display("done reject");
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge sys_clk_in);
        #1 rst_n_in = 1'b1;
        chk("tx idle", 16'h1, {15'h0, lin_tx});
        chk("counter", 16'h0, cnt);
        t_rx(1'b0);
        t_rx(1'b1);
        t_tx();
        t_reject();
        tally_and_finish();
    end
    // Hang guard
    initial
    begin
        repeat (90000) @(posedge sys_clk_in);
        fails++;
        tally_and_finish();
    end
endmodule

bind lin_responder_frame_receiver lin_responder_monitor mon (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .lin_tx_out(lin_tx_out),
    .edge_interval_counter_out(edge_interval_counter_out),
    .rise_capture_evt_out(rise_capture_evt_out), .break_seen_out(break_seen_out),
    .sync_error_out(sync_error_out), .frame_ok_out(frame_ok_out),
    .rx_valid_out(rx_valid_out), .rx_data_out(rx_data_out), .rx_ready_in(rx_ready_in));
